// >>> hw/zra_pkg.sv
// Package: constants and types for the zone relay alarm logic
package zra_pkg;
    localparam int          ZRA_ZONES       = 9;         // Zone relay count
    localparam int          ZRA_MODS        = 5;         // Remote relay module count
    localparam int          ZRA_MOD_OUTS    = 4;         // Zone mapped outputs per module
    localparam logic [7:0]  ZRA_MOD_ADDR_LO = 8'h1e;     // First module address (30)
    localparam logic [7:0]  ZRA_MOD_ADDR_HI = 8'h22;     // Last module address (34)
    localparam int          ZRA_CLK_HZ      = 50000000;  // System clock rate
    localparam int          ZRA_TICK_S      = 1;         // Delay tick period in seconds
    localparam int          ZRA_TICK_CYC    = ZRA_CLK_HZ * ZRA_TICK_S;  // Cycles per tick
    localparam logic [5:0]  ZRA_MAX_MIN     = 6'h3b;     // Largest minutes field (59)
    localparam logic [5:0]  ZRA_MAX_SEC     = 6'h3b;     // Largest seconds field (59)
    localparam logic [11:0] ZRA_SEC_PER_MIN = 12'h03c;   // Seconds per minute
    localparam logic        ZRA_MOD_POL_NC  = 1'b0;      // Module polarity code: closed
    localparam logic        ZRA_MOD_POL_NO  = 1'b1;      // Module polarity code: open
    localparam logic [1:0]  ZRA_DLY_NONE    = 2'h0;      // Delay type: none
    localparam logic [1:0]  ZRA_DLY_ON      = 2'h1;      // Delay type: on-delay
    localparam logic [1:0]  ZRA_DLY_OFF     = 2'h2;      // Delay type: off-delay
    localparam int          ZRA_FKINDS      = 14;        // Decoded sensor fault kinds
    localparam logic [3:0]  ZRA_FK_GENERAL  = 4'hf;      // Code for any other fault
    // Transmitter poll sequencer states
    typedef enum logic [1:0] {
        ZRA_POLL_RUN   = 2'b01,
        ZRA_POLL_PAUSE = 2'b10
    } zra_poll_e;
endpackage

// >>> hw/zra_alarm_logic.sv
// Zone relay, horn, fault relay and poll sequencing logic
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [RULE_01] Contact closes active if open, opens if closed
// [RULE_02] Latching zone holds alarm after condition ends
// [RULE_03] Only local unlatch command releases latched zone
// [RULE_04] Non-latching zone releases when condition ends
// [RULE_05] Delays apply only to non-latching zones
// [RULE_06] On-delay alarms after full delay while active
// [RULE_07] Off-delay holds alarm delay time after clear
// [RULE_08] Delay type none/on/off, time 00:00 to 59:59
// [RULE_09] Module outputs one-four follow mapped zones
// [RULE_10] Module output zero is horn, always closed-type
// [RULE_11] Module polarity 0 closed 1 open, outputs 1-4
// [RULE_12] Five modules at addresses thirty to thirty-four
// [RULE_13] Selected module offline until answer at address
// [RULE_14] Fault relay on when any transmitter comm fails
// [RULE_15] All-units-lost flag when every transmitter fails
// [RULE_16] Silence turns horns off; needs-silence while sounding
// [RULE_17] Silence never clears a latched zone
// [RULE_18] Zone-latched flag while any zone latched
// [RULE_19] Running steps addresses; paused holds current address
// [RULE_20] Remote unlatch requests unlatch on every transmitter
// [RULE_21] Fourteen fault kinds decoded, others general
// [RULE_22] Delay timers count seconds, restart on change
module zra_alarm_logic
    import zra_pkg::*;
#(
    parameter int TICK_CYC = ZRA_TICK_CYC,  // Cycles per one-second tick
    parameter int NUM_TX   = 16,            // Polled transmitter count
    parameter int TXA_W    = 8              // Transmitter address width
) (
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          nrst,

    // Zone alarm conditions and settings
    input  wire logic [ZRA_ZONES-1:0]          zone_cond,
    input  wire logic [ZRA_ZONES-1:0]          zone_pol_no,
    input  wire logic [ZRA_ZONES-1:0]          zone_latch_en,
    input  wire logic [ZRA_ZONES*2-1:0]        zone_dly_type,
    input  wire logic [ZRA_ZONES*6-1:0]        zone_dly_min,
    input  wire logic [ZRA_ZONES*6-1:0]        zone_dly_sec,

    // Operator buttons, one-cycle pulses
    input  wire logic                          unlatch_local,
    input  wire logic                          unlatch_remote,
    input  wire logic                          silence,
    input  wire logic                          run_toggle,
    input  wire logic                          pick_addr_req,
    input  wire logic [TXA_W-1:0]              pick_addr,

    // Remote module settings and answers
    input  wire logic [ZRA_MODS-1:0]           mod_sel,
    input  wire logic [ZRA_MODS-1:0]           mod_pol,
    input  wire logic [ZRA_MODS*ZRA_MOD_OUTS*ZRA_ZONES-1:0] mod_map,
    input  wire logic                          mod_answer,
    input  wire logic [TXA_W-1:0]              mod_answer_addr,

    // Transmitter link status
    input  wire logic [NUM_TX-1:0]             tx_polled,
    input  wire logic [NUM_TX-1:0]             tx_comm_fail,
    input  wire logic [7:0]                    fault_code,

    // Zone and module relay contacts (1 = closed), zone alarm and module offline flags
    output logic [ZRA_ZONES-1:0]               zone_contact,
    output logic [ZRA_ZONES-1:0]               zone_alarm,
    output logic [ZRA_MODS-1:0]                horn_output,
    output logic [ZRA_MODS*ZRA_MOD_OUTS-1:0]   zone_mapped_outputs,
    output logic [ZRA_MODS-1:0]                mod_offline,

    // Indicators
    output logic                               fault_relay,
    output logic                               all_units_lost,
    output logic                               horn_needs_silence,
    output logic                               zone_latched,
    output logic                               remote_unlatch_req,
    output logic [3:0]                         fault_kind,
    output logic                               polling_run,
    output logic [TXA_W-1:0]                   transmitter_address
);
    // One-second tick divider
    logic [31:0]          tick_cnt_r;   // Cycle count within a second
    logic                 tick;         // One-cycle second pulse

    assign tick = (tick_cnt_r == 32'(TICK_CYC - 1)); // [RULE_22]

    // Second divider
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) tick_cnt_r <= 32'h0;
        else if (tick) tick_cnt_r <= 32'h0;
        else tick_cnt_r <= tick_cnt_r + 32'h1;
    end

    // Per-zone state
    logic [ZRA_ZONES-1:0] alarm_r;      // Zone in alarming state
    logic [ZRA_ZONES-1:0] latched_r;    // Zone held by latch
    logic [ZRA_ZONES-1:0] cond_q_r;     // Condition seen last cycle

    genvar z;
    generate
        for (z = 0; z < ZRA_ZONES; z++) begin : g_zone
            logic [11:0] secs_r;        // Elapsed whole seconds
            logic [11:0] dly_sec;       // Delay limit in seconds
            logic [5:0]  mm;            // Minutes field clamped
            logic [5:0]  ss;            // Seconds field clamped
            logic [1:0]  dtype;         // Effective delay type
            logic        done;          // Delay fully elapsed
            logic        alarm_nxt;     // Next alarming state
            logic [11:0] secs_eff;      // Seconds as seen now

            assign mm = (zone_dly_min[z*6 +: 6] > ZRA_MAX_MIN) ? ZRA_MAX_MIN
                                                                : zone_dly_min[z*6 +: 6]; // [RULE_08]
            assign ss = (zone_dly_sec[z*6 +: 6] > ZRA_MAX_SEC) ? ZRA_MAX_SEC
                                                                : zone_dly_sec[z*6 +: 6]; // [RULE_08]
            assign dly_sec = 12'(mm * ZRA_SEC_PER_MIN) + {6'h0, ss};

            // Latching masks off the delay settings
            assign dtype = zone_latch_en[z] ? ZRA_DLY_NONE : zone_dly_type[z*2 +: 2]; // [RULE_05]
            // Edge reads as zero
            assign secs_eff = (zone_cond[z] != cond_q_r[z]) ? 12'h0 : secs_r; // [RULE_22]
            assign done     = (secs_eff >= dly_sec);

            // Next alarming state per delay type
            always_comb begin
                alarm_nxt = zone_cond[z];               // [RULE_04]
                if (dtype == ZRA_DLY_ON) begin
                    alarm_nxt = zone_cond[z] && (alarm_r[z] || done); // [RULE_06]
                end else if (dtype == ZRA_DLY_OFF) begin
                    alarm_nxt = zone_cond[z] || (alarm_r[z] && !done); // [RULE_07]
                end
                if (latched_r[z]) begin
                    alarm_nxt = 1'b1;                   // [RULE_02]
                end
            end

            // Seconds timer restarts on each condition edge
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) secs_r <= 12'h0;
                else if (zone_cond[z] != cond_q_r[z]) secs_r <= 12'h0; // [RULE_22]
                else if (tick && !done) secs_r <= secs_r + 12'h1;      // [RULE_22]
            end

            // Alarm and latch state; silence has no effect here
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    alarm_r[z]   <= 1'b0;
                    latched_r[z] <= 1'b0;
                    cond_q_r[z]  <= 1'b0;
                end else begin
                    cond_q_r[z] <= zone_cond[z];
                    if (zone_latch_en[z] && zone_cond[z]) begin
                        latched_r[z] <= 1'b1;           // [RULE_02]
                        alarm_r[z]   <= 1'b1;
                    end else if (unlatch_local && latched_r[z]) begin
                        latched_r[z] <= 1'b0;           // [RULE_03] [RULE_17]
                        alarm_r[z]   <= zone_cond[z] && (dtype != ZRA_DLY_ON);
                    end else begin
                        alarm_r[z]   <= alarm_nxt;
                    end
                end
            end
        end
    endgenerate

    // Contact drive from polarity
    assign zone_alarm   = alarm_r;
    assign zone_contact = ~(alarm_r ^ zone_pol_no);    // [RULE_01]
    // Any zone latched
    assign zone_latched = |latched_r;                  // [RULE_18]

    // Horn state: sounds on any new alarm, silence turns it off
    logic                 horn_on_r;    // Horns sounding
    logic [ZRA_ZONES-1:0] alarm_q_r;    // Alarm state last cycle
    logic                 new_alarm;    // A zone just went alarming

    assign new_alarm = |(alarm_r & ~alarm_q_r);

    // Horn set and clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            horn_on_r <= 1'b0;
            alarm_q_r <= '0;
        end else begin
            alarm_q_r <= alarm_r;
            if (new_alarm) horn_on_r <= 1'b1;           // Set wins over silence
            else if (silence || !(|alarm_r)) horn_on_r <= 1'b0; // [RULE_16]
        end
    end

    // Panel indicator
    assign horn_needs_silence = horn_on_r;             // [RULE_16]

    // Remote module outputs
    genvar m, o;
    generate
        for (m = 0; m < ZRA_MODS; m++) begin : g_mod
            // Horn output is always closed-type: opens while sounding
            assign horn_output[m] = ~horn_on_r;         // [RULE_10]

            for (o = 0; o < ZRA_MOD_OUTS; o++) begin : g_out
                logic act;              // Any mapped zone alarming
                assign act = |(alarm_r & mod_map[(m*ZRA_MOD_OUTS+o)*ZRA_ZONES +: ZRA_ZONES]); // [RULE_09]
                assign zone_mapped_outputs[m*ZRA_MOD_OUTS+o] =
                    (mod_pol[m] == ZRA_MOD_POL_NO) ? act : ~act; // [RULE_11]
            end
        end
    endgenerate

    // Module presence tracking
    logic [ZRA_MODS-1:0]  seen_r;       // Module answered at its address
    logic [TXA_W-1:0]     ans_idx;      // Answer address minus base
    logic                 ans_ok;       // Answer lies in module range

    assign ans_ok  = mod_answer && (mod_answer_addr >= TXA_W'(ZRA_MOD_ADDR_LO))
                                && (mod_answer_addr <= TXA_W'(ZRA_MOD_ADDR_HI)); // [RULE_12]
    assign ans_idx = mod_answer_addr - TXA_W'(ZRA_MOD_ADDR_LO);

    // Deselect forgets answers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) seen_r <= '0;
        else begin
            for (int i = 0; i < ZRA_MODS; i++) begin
                if (!mod_sel[i]) seen_r[i] <= 1'b0;
                else if (ans_ok && ans_idx == TXA_W'(i)) seen_r[i] <= 1'b1; // [RULE_13]
            end
        end
    end

    // Offline until heard
    assign mod_offline = mod_sel & ~seen_r;            // [RULE_13]

    // Communication fault indications
    logic [NUM_TX-1:0]    lost;         // Polled and failing

    assign lost           = tx_polled & tx_comm_fail;
    // Comm fault relay
    assign fault_relay    = |lost;                                  // [RULE_14]
    assign all_units_lost = (|tx_polled) && (lost == tx_polled);    // [RULE_15]

    // Remote unlatch request pulse to all transmitters
    logic                 runl_r;       // Broadcast unlatch pulse

    // One-cycle broadcast
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) runl_r <= 1'b0;
        else runl_r <= unlatch_remote;                  // [RULE_20]
    end

    // To every transmitter
    assign remote_unlatch_req = runl_r;

    // Fault code decode: codes 0..13 specific, rest general
    logic [3:0]           fk_r;         // Decoded fault kind

    // Reset reads general
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) fk_r <= ZRA_FK_GENERAL;
        else if (fault_code < 8'(ZRA_FKINDS)) fk_r <= fault_code[3:0]; // [RULE_21]
        else fk_r <= ZRA_FK_GENERAL;                    // [RULE_21]
    end

    assign fault_kind = fk_r;

    // Poll sequencer
    zra_poll_e            poll_r;       // Running or paused
    logic [TXA_W-1:0]     addr_r;       // Current transmitter address

    // Pick wins over toggle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            poll_r <= ZRA_POLL_RUN;
            addr_r <= '0;
        end else begin
            if (pick_addr_req) begin
                poll_r <= ZRA_POLL_PAUSE;
                addr_r <= pick_addr;
            end else begin
                case (poll_r)
                    ZRA_POLL_RUN: begin
                        if (run_toggle) poll_r <= ZRA_POLL_PAUSE;
                        else if (tick) begin    // [RULE_19]
                            addr_r <= (addr_r == TXA_W'(NUM_TX - 1)) ? '0 : addr_r + 1'b1;
                        end
                    end
                    ZRA_POLL_PAUSE: begin
                        if (run_toggle) poll_r <= ZRA_POLL_RUN; // [RULE_19]
                    end
                    default: poll_r <= ZRA_POLL_RUN;
                endcase
            end
        end
    end

    // Sequencer to panel
    assign polling_run         = (poll_r == ZRA_POLL_RUN);
    assign transmitter_address = addr_r;
endmodule

`default_nettype wire

// >>> verification/zra_sva.sv
// Checker: concurrent properties of the zone relay alarm logic
`timescale 1ns/100ps
`default_nettype none
module zra_sva
    import zra_pkg::*;
#(
    parameter int NUM_TX = 16  // Polled transmitter count
) (
    // Clock, reset and watched inputs
    input wire logic                 mclk, nrst, unlatch_local, silence,
    input wire logic [ZRA_ZONES-1:0] zone_cond, zone_pol_no, zone_latch_en,
    input wire logic [ZRA_ZONES*2-1:0] zone_dly_type,
    input wire logic [ZRA_MODS-1:0]  mod_pol,
    input wire logic [ZRA_MODS*ZRA_MOD_OUTS*ZRA_ZONES-1:0] mod_map,
    input wire logic [NUM_TX-1:0]    tx_polled, tx_comm_fail,
    input wire logic [7:0]           fault_code,
    // Watched outputs
    input wire logic [ZRA_ZONES-1:0] zone_contact, zone_alarm,
    input wire logic [ZRA_MODS-1:0]  horn_output,
    input wire logic [ZRA_MODS*ZRA_MOD_OUTS-1:0] zone_mapped_outputs,
    input wire logic                 fault_relay, all_units_lost, horn_needs_silence,
    input wire logic                 zone_latched,
    input wire logic [3:0]           fault_kind
);
    logic [ZRA_ZONES-1:0]             no_dly;    // Delay type reads as none
    logic [ZRA_MODS*ZRA_MOD_OUTS-1:0] map_exp;   // Expected module contacts
    wire logic                        all_fail = (tx_polled != '0) && ((tx_polled & ~tx_comm_fail) == '0);
    // Decode delay types and expected module output contacts
    always_comb begin
        for (int i = 0; i < ZRA_ZONES; i++) begin
            no_dly[i] = zone_dly_type[2*i] == zone_dly_type[2*i+1];
        end
        for (int j = 0; j < ZRA_MODS*ZRA_MOD_OUTS; j++) begin
            map_exp[j] = ~(mod_pol[j/ZRA_MOD_OUTS] ^ (|(mod_map[j*ZRA_ZONES +: ZRA_ZONES] & zone_alarm)));
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    contact_pol_a: assert property (zone_contact == ~(zone_alarm ^ zone_pol_no))
        else $error("zone contact polarity wrong");
    latch_hold_a: assert property (!unlatch_local |=> ($past(zone_alarm & zone_latch_en) & ~zone_alarm) == '0)
        else $error("latched zone dropped without unlatch");
    zone_follow_a: assert property ($past(nrst) |-> ((zone_alarm ^ $past(zone_cond)) & $past(~zone_latch_en & no_dly)) == '0)
        else $error("plain zone does not follow its condition");
    horn_out_a: assert property (horn_output == {ZRA_MODS{~horn_needs_silence}})
        else $error("horn output not closed-type");
    silence_a: assert property (silence |=> !horn_needs_silence || (|($past(zone_alarm) & ~$past(zone_alarm, 2))))
        else $error("silence left horn sounding");
    latch_sil_a: assert property (zone_latched && !unlatch_local |=> zone_latched)
        else $error("latched flag cleared without unlatch");
    latch_flag_a: assert property ((zone_alarm & zone_latch_en) != '0 |-> zone_latched)
        else $error("latched flag missing");
    fault_rly_a: assert property (fault_relay == |(tx_polled & tx_comm_fail))
        else $error("fault relay wrong");
    all_lost_a: assert property (all_fail |-> all_units_lost && fault_relay)
        else $error("all units lost flag missing");
    fault_kind_a: assert property ($past(nrst) |-> fault_kind == (($past(fault_code) < 8'h0e) ? 4'($past(fault_code)) : ZRA_FK_GENERAL))
        else $error("fault kind decode wrong");
    mod_map_a: assert property (zone_mapped_outputs == map_exp)
        else $error("module mapped output wrong");
    // Main scenarios reached
    silence_c: cover property (silence && horn_needs_silence);
    unlatch_c: cover property (zone_latched && unlatch_local);
    lost_c: cover property (all_units_lost);
endmodule
bind zra_alarm_logic zra_sva #(.NUM_TX(NUM_TX)) u_sva (
    .mclk(mclk), .nrst(nrst), .unlatch_local(unlatch_local), .silence(silence),
    .zone_cond(zone_cond), .zone_pol_no(zone_pol_no), .zone_latch_en(zone_latch_en),
    .zone_dly_type(zone_dly_type), .mod_pol(mod_pol), .mod_map(mod_map),
    .tx_polled(tx_polled), .tx_comm_fail(tx_comm_fail), .fault_code(fault_code),
    .zone_contact(zone_contact), .zone_alarm(zone_alarm), .horn_output(horn_output),
    .zone_mapped_outputs(zone_mapped_outputs), .fault_relay(fault_relay),
    .all_units_lost(all_units_lost), .horn_needs_silence(horn_needs_silence),
    .zone_latched(zone_latched), .fault_kind(fault_kind));
`default_nettype wire

// >>> verification/zra_partner.sv
// Model of the remote relay modules and the polled transmitters
`timescale 1ns/100ps
`default_nettype none
module zra_partner
    import zra_pkg::*;
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                nrst,
    // Modules set to their address, transmitters that stop answering
    input  wire logic [ZRA_MODS-1:0] mod_set,
    input  wire logic [15:0]         tx_dead,
    // Answers towards the alarm logic
    output logic                     mod_answer,
    output logic [7:0]               mod_answer_addr,
    output logic [15:0]              tx_comm_fail
);
    logic [4:0] slot_r;                     // Answer slot, four cycles per module
    wire logic [2:0] idx = slot_r[4:2];     // Module whose turn it is; 5 is a stray
    // Modules answer in turn at 30+i; a stray unit answers at 35
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            slot_r <= 5'h00;
            mod_answer <= 1'b0;
            mod_answer_addr <= 8'h00;
            tx_comm_fail <= 16'h0000;
        end else begin
            slot_r <= (slot_r == 5'h17) ? 5'h00 : slot_r + 5'h01;
            tx_comm_fail <= tx_dead;
            if (slot_r[1:0] == 2'h0) begin
                mod_answer <= (idx == 3'h5) || (idx < 3'h5 && mod_set[idx]);
                mod_answer_addr <= ZRA_MOD_ADDR_LO + 8'(idx);
            end else begin
                // No valid address between answers
                mod_answer <= 1'b0;
                mod_answer_addr <= ~mod_answer_addr;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking testbench for the zone relay alarm logic
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import zra_pkg::*;
    localparam int TICK = 10;  // Short delay tick for simulation
    logic mclk = 0, nrst = 0, unlatch_local = 0, unlatch_remote = 0, silence = 0;
    logic run_toggle = 0, pick_addr_req = 0, mod_answer, fault_relay, all_units_lost;
    logic horn_needs_silence, zone_latched, remote_unlatch_req, polling_run;
    logic [8:0] zone_cond = '0, zone_pol_no = 9'h0f0, zone_latch_en = '0, zone_contact, zone_alarm;
    logic [17:0] zone_dly_type = '0;
    logic [53:0] zone_dly_min = '0, zone_dly_sec = '0;
    logic [7:0] pick_addr = '0, fault_code = '0, mod_answer_addr, transmitter_address, a;
    logic [4:0] mod_sel = '0, mod_pol = '0, mod_set = '0, horn_output, mod_offline, r;
    logic [179:0] mod_map = '0;
    logic [15:0] tx_polled = '0, tx_dead = '0, tx_comm_fail;
    logic [19:0] zone_mapped_outputs;
    logic [3:0] fault_kind;
    int n_mismatch = 0, check_count = 0, seed = 87, cyc = 0, n;
    zra_alarm_logic #(.TICK_CYC(TICK)) uut (.mclk(mclk), .nrst(nrst), .zone_cond(zone_cond),
        .zone_pol_no(zone_pol_no), .zone_latch_en(zone_latch_en), .zone_dly_type(zone_dly_type),
        .zone_dly_min(zone_dly_min), .zone_dly_sec(zone_dly_sec), .unlatch_local(unlatch_local),
        .unlatch_remote(unlatch_remote), .silence(silence), .run_toggle(run_toggle),
        .pick_addr_req(pick_addr_req), .pick_addr(pick_addr), .mod_sel(mod_sel), .mod_pol(mod_pol),
        .mod_map(mod_map), .mod_answer(mod_answer), .mod_answer_addr(mod_answer_addr),
        .tx_polled(tx_polled), .tx_comm_fail(tx_comm_fail), .fault_code(fault_code),
        .zone_contact(zone_contact), .zone_alarm(zone_alarm), .horn_output(horn_output),
        .zone_mapped_outputs(zone_mapped_outputs), .mod_offline(mod_offline),
        .fault_relay(fault_relay), .all_units_lost(all_units_lost), .zone_latched(zone_latched),
        .horn_needs_silence(horn_needs_silence), .remote_unlatch_req(remote_unlatch_req),
        .fault_kind(fault_kind), .polling_run(polling_run), .transmitter_address(transmitter_address));
    zra_partner u_far (.mclk(mclk), .nrst(nrst), .mod_set(mod_set), .tx_dead(tx_dead),
        .mod_answer(mod_answer), .mod_answer_addr(mod_answer_addr), .tx_comm_fail(tx_comm_fail));
    initial begin
        forever #10 mclk = ~mclk;
    end
    // Cut a hang short
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic tick(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Bounded wait on a zone level
    task automatic wait_lvl(input int z, input logic v, input int max);
        n = 0;
        while (zone_alarm[z] !== v && n < max) begin
            tick(1);
            n++;
        end
    endtask
    function automatic logic [3:0] fkind(input logic [7:0] c);
        return (c < 8'h0e) ? c[3:0] : ZRA_FK_GENERAL;
    endfunction
    function automatic logic lost(input logic [15:0] p, input logic [15:0] d);
        return (p != '0) && ((p & ~d) == '0);
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        tick(5);
        chk(zone_contact, 9'(~zone_pol_no));
        chk({horn_output, fault_kind, polling_run}, {5'h1f, 4'hf, 1'b1});
        nrst = 1;
        zone_pol_no = 9'h001;
        zone_cond[0] = 1;
        tick(2);
        chk({zone_alarm[0], zone_contact[0], horn_needs_silence, horn_output}, 8'he0);
        silence = 1;
        tick(1);
        silence = 0;
        chk({horn_needs_silence, horn_output}, 6'h1f);
        zone_cond[0] = 0;
        tick(2);
        chk(zone_alarm[0], 0);
        $display("test plain zone done");
        zone_latch_en[1] = 1;
        zone_dly_type[3:2] = ZRA_DLY_ON;
        zone_dly_min[11:6] = 6'h3b;
        zone_dly_sec[11:6] = 6'h3b;
        zone_cond[1] = 1;
        tick(2);
        chk(zone_alarm[1], 1);
        zone_cond[1] = 0;
        silence = 1;
        tick(3);
        silence = 0;
        chk({zone_alarm[1], zone_latched}, 2'h3);
        unlatch_local = 1;
        tick(1);
        unlatch_local = 0;
        tick(1);
        chk({zone_alarm[1], zone_latched}, 2'h0);
        $display("test latch done");
        zone_dly_type[5:4] = ZRA_DLY_ON;
        zone_dly_sec[17:12] = 6'h03;
        zone_cond[2] = 1;
        tick(15);
        zone_cond[2] = 0;
        tick(2);
        zone_cond[2] = 1;
        tick(19);
        chk(zone_alarm[2], 0);
        wait_lvl(2, 1, 15);
        chk(zone_alarm[2], 1);
        zone_dly_type[7:6] = ZRA_DLY_OFF;
        zone_dly_min[23:18] = 6'h01;
        zone_cond[3] = 1;
        tick(2);
        zone_cond[3] = 0;
        tick(580);
        chk(zone_alarm[3], 1);
        wait_lvl(3, 0, 50);
        chk(zone_alarm[3], 0);
        $display("test delays done");
        mod_sel = 5'h1f;
        mod_set = 5'h0f;
        mod_pol[2] = 1;
        mod_map[81] = 1;
        zone_cond[2:0] = 3'h1;
        tick(30);
        chk(mod_offline, 5'h10);
        chk({zone_mapped_outputs[9], horn_output[2]}, 2'h2);
        mod_pol[2] = 0;
        mod_set = 5'h1f;
        tick(30);
        chk({mod_offline, zone_mapped_outputs[9]}, 6'h00);
        $display("test modules done");
        for (int i = 0; i < 24; i++) begin
            fault_code = (i < 20) ? 8'(i) : 8'($random(seed));
            tx_polled = (i < 2) ? 16'h00ff : 16'($random(seed));
            tx_dead = (i == 0) ? 16'hff00 : (i == 1) ? 16'hffff : 16'($random(seed));
            tick(2);
            chk(fault_kind, fkind(fault_code));
            chk({fault_relay, all_units_lost}, {|(tx_polled & tx_dead), lost(tx_polled, tx_dead)});
        end
        $display("test faults done");
        unlatch_remote = 1;
        zone_cond[2] = 1;
        tick(1);
        unlatch_remote = 0;
        chk(remote_unlatch_req, 1);
        tick(1);
        chk(remote_unlatch_req, 0);
        chk(zone_alarm[2], 0);
        a = transmitter_address;
        n = 0;
        while (transmitter_address === a && n < 15) begin
            tick(1);
            n++;
        end
        chk(transmitter_address, (a + 8'h01) % 8'h10);
        run_toggle = 1;
        tick(1);
        run_toggle = 0;
        a = transmitter_address;
        tick(30);
        chk({polling_run, transmitter_address}, {1'b0, a});
        pick_addr = 8'h07;
        pick_addr_req = 1;
        tick(1);
        pick_addr_req = 0;
        run_toggle = 1;
        tick(1);
        run_toggle = 0;
        chk(transmitter_address, 8'h07);
        tick(1);
        chk(polling_run, 1);
        $display("test polling done");
        for (int i = 0; i < 300; i++) begin
            r = 5'($random(seed));
            zone_cond[8:4] = r;
            zone_pol_no = 9'($random(seed));
            mod_pol = 5'($random(seed));
            mod_map = {6{30'($random(seed))}};
            silence = ($random(seed) & 7) == 0;
            tick(1);
            chk(zone_alarm[8:4], r);
            chk(zone_contact[8:4], 5'(~(r ^ zone_pol_no[8:4])));
        end
        $display("test random done");
        close_out();
    end
endmodule
`default_nettype wire
